// File: inc/dch_pkg.sv
// Shared constants and types for the DMA handshake and buffer-process block.
// Assumes a 32-bit AXI4-Lite register bus and a single 25 MHz bus clock.
package dch_pkg;

	localparam int unsigned NUM_CH = 8;

	// Register window: one 32-byte slot per channel
	localparam logic [4:0] OFF_CTRL     = 5'h00;
	localparam logic [4:0] OFF_BASE_REQ = 5'h04;
	localparam logic [4:0] OFF_BASE_TGT = 5'h08;
	localparam logic [4:0] OFF_BASE_CNT = 5'h0C;
	localparam logic [4:0] OFF_CUR_REQ  = 5'h10;
	localparam logic [4:0] OFF_CUR_TGT  = 5'h14;
	localparam logic [4:0] OFF_CUR_CNT  = 5'h18;
	localparam logic [4:0] OFF_STATUS   = 5'h1C;
	localparam int unsigned CH_SEL_LSB  = 5;
	localparam int unsigned WIN_MSB     = 7;

	// Status register field positions
	localparam int unsigned ST_ARMED_BIT  = 0;
	localparam int unsigned ST_DONE_BIT   = 1;
	localparam int unsigned ST_ACTIVE_BIT = 2;

	localparam logic [2:0]  ACK_IDLE      = 3'h4;
	localparam logic [2:0]  ACK_NONE_CH   = 3'h4;
	localparam logic [31:0] WORD_RST      = 32'h0000_0000;
	localparam logic [1:0]  RESP_OKAY     = 2'h0;
	localparam logic [1:0]  RESP_SLVERR   = 2'h2;
	localparam logic [1:0]  EOP_BLANK_CYC = 2'h3;

	typedef enum logic [1:0] {
		STEP_INC  = 2'h0,
		STEP_DEC  = 2'h1,
		STEP_HOLD = 2'h2
	} dch_step_t;

	// Control register, bit 0 upward: enable, auto_init, dir_write,
	// req_step[1:0], tgt_step[1:0], req_sync, eop_sync
	typedef struct packed {
		logic      eop_sync;
		logic      req_sync;
		dch_step_t tgt_step;
		dch_step_t req_step;
		logic      dir_write;
		logic      auto_init;
		logic      enable;
	} dch_ctrl_t;

	localparam int unsigned CTRL_W   = $bits(dch_ctrl_t);
	localparam dch_ctrl_t   CTRL_RST = '0;

	// Master-side bus cycle as driven while holding the bus
	typedef struct packed {
		logic [31:0] addr;
		logic        write;
		logic        strobe;
		logic        t2;
		logic        refresh;
	} dch_bus_t;

endpackage

// File: src/dch_pin_sampler.sv
// Pin sampler for one handshake input, selectable synchronous or filtered.
// Assumes the pin is asynchronous to aclk; three flip-flops sit in line in synchronous mode, four when filtered.
module dch_pin_sampler
	import dch_pkg::*;
#(
	parameter logic RESET_LEVEL = 1'b0
)
(
	input  wire logic aclk,
	input  wire logic aresetn,
	input  wire logic pin,
	input  wire logic sync_mode,
	output logic      level
);

	logic s1_q;
	logic s2_q;
	logic s3_q;

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			s1_q  <= RESET_LEVEL;
			s2_q  <= RESET_LEVEL;
			s3_q  <= RESET_LEVEL;
			level <= RESET_LEVEL;
		end
		else
		begin
			s1_q <= pin;
			s2_q <= s1_q;
			s3_q <= s2_q;
			// Synchronous mode trusts the pin timing and saves a cycle
			if (sync_mode)
				level <= s2_q;
			else if (s2_q == s3_q)
				level <= s3_q;
		end
	end

endmodule

// File: src/dch_dma_handshake.sv
// Eight-channel DMA handshake and buffer-process controller with AXI4-Lite registers.
// Assumes host and refresh requester on aclk; peripheral pins are asynchronous.
//
// The AXI4-Lite interface to the registers and the address map were chosen for this implementation.
module dch_dma_handshake
	import dch_pkg::*;
(
	input  wire logic        aclk,
	input  wire logic        aresetn,
	// AXI4-Lite slave
	input  wire logic [31:0] s_axi_awaddr,
	input  wire logic        s_axi_awvalid,
	output logic             s_axi_awready,
	input  wire logic [31:0] s_axi_wdata,
	input  wire logic [3:0]  s_axi_wstrb,
	input  wire logic        s_axi_wvalid,
	output logic             s_axi_wready,
	output logic [1:0]       s_axi_bresp,
	output logic             s_axi_bvalid,
	input  wire logic        s_axi_bready,
	input  wire logic [31:0] s_axi_araddr,
	input  wire logic        s_axi_arvalid,
	output logic             s_axi_arready,
	output logic [31:0]      s_axi_rdata,
	output logic [1:0]       s_axi_rresp,
	output logic             s_axi_rvalid,
	input  wire logic        s_axi_rready,
	// Peripheral handshake
	input  wire logic [7:0]  channel_request,
	output logic [2:0]       encoded_channel_ack,
	input  wire logic        end_of_process_line_n_in,
	output logic             end_of_process_line_n_out,
	output logic             end_of_process_line_n_oe_n,
	// Host and refresh
	output logic             bus_hold_request,
	input  wire logic        bus_hold_grant,
	input  wire logic        refresh_request,
	output dch_bus_t         dma_bus
);

	typedef enum logic [2:0] {ST_IDLE, ST_HOLD, ST_T1, ST_T2, ST_RF1, ST_RF2} dch_state_t;

	dch_ctrl_t   cfg_q      [NUM_CH];
	logic [31:0] base_req_q [NUM_CH];
	logic [31:0] base_tgt_q [NUM_CH];
	logic [31:0] base_cnt_q [NUM_CH];
	logic [31:0] cur_req_q  [NUM_CH];
	logic [31:0] cur_tgt_q  [NUM_CH];
	logic [31:0] cur_cnt_q  [NUM_CH];
	logic [7:0]  armed_q;
	logic [7:0]  done_q;
	logic [7:0]  req_s;
	logic [7:0]  pend;
	logic        eop_s_n;
	dch_state_t  state_q;
	dch_state_t  state_d;
	logic [2:0]  ch_q;
	logic [2:0]  ch_d;
	logic        phase_q;
	logic        phase_d;
	logic        resume_q;
	logic        eop_seen_q;
	logic [1:0]  eop_blank_q;
	logic        pair_end;
	logic        term;
	logic        cont;
	logic        is_req_d;
	logic        aw_hold_q;
	logic        w_hold_q;
	logic [31:0] awaddr_q;
	logic [31:0] wdata_q;
	logic [3:0]  wstrb_q;
	logic        do_write;
	logic [2:0]  wch;
	logic [4:0]  woff;
	logic        wmapped;
	logic [31:0] rd_word;
	logic        rd_ok;

	// Synchronous mode trades metastability margin for latency
	for (genvar i = 0; i < NUM_CH; i++)
	begin : g_req
		dch_pin_sampler #(.RESET_LEVEL(1'b0)) u_req (
			.aclk      (aclk),
			.aresetn   (aresetn),
			.pin       (channel_request[i]),
			.sync_mode (cfg_q[i].req_sync),
			.level     (req_s[i])
		);
	end

	dch_pin_sampler #(.RESET_LEVEL(1'b1)) u_eop (
		.aclk      (aclk),
		.aresetn   (aresetn),
		.pin       (end_of_process_line_n_in),
		.sync_mode (cfg_q[ch_q].eop_sync),
		.level     (eop_s_n)
	);

	function automatic logic [2:0] pick_lowest(input logic [7:0] p);
		logic [2:0] r;
		r = 3'h0;
		for (int k = NUM_CH - 1; k >= 0; k--)
			if (p[k])
				r = 3'(k);
		return r;
	endfunction

	function automatic logic [31:0] step_addr(input logic [31:0] a, input dch_step_t s);
		logic [31:0] r;
		r = a;
		if (s == STEP_INC)
			r = a + 32'h0000_0001;
		else if (s == STEP_DEC)
			r = a - 32'h0000_0001;
		return r;
	endfunction

	function automatic logic [31:0] merge(input logic [31:0] o, input logic [31:0] d,
		input logic [3:0] s);
		logic [31:0] r;
		r = o;
		for (int b = 0; b < 4; b++)
			if (s[b])
				r[b*8 +: 8] = d[b*8 +: 8];
		return r;
	endfunction

	assign pend     = armed_q & req_s;
	assign pair_end = (state_q == ST_T2) && phase_q;
	assign term     = (cur_cnt_q[ch_q] == WORD_RST) || eop_seen_q;
	assign cont     = !term && bus_hold_grant && pend[ch_q];
	// Write transfer reads the requester first; read transfer ends on it
	assign is_req_d = (phase_d == 1'b0) == cfg_q[ch_d].dir_write;

	always_comb
	begin
		state_d = state_q;
		ch_d    = ch_q;
		phase_d = phase_q;
		case (state_q)
			ST_IDLE:
				if (refresh_request || (pend != 8'h00))
					state_d = ST_HOLD;
			ST_HOLD:
				if (bus_hold_grant)
				begin
					if (refresh_request)
						state_d = ST_RF1;
					else if (pend != 8'h00)
					begin
						state_d = ST_T1;
						ch_d    = pick_lowest(pend);
						phase_d = 1'b0;
					end
					else
						state_d = ST_IDLE;
				end
				else if (!refresh_request && (pend == 8'h00))
					state_d = ST_IDLE;
			ST_T1:
				state_d = ST_T2;
			ST_T2:
				if (!phase_q)
				begin
					state_d = ST_T1;
					phase_d = 1'b1;
				end
				else
				begin
					phase_d = 1'b0;
					if (refresh_request && bus_hold_grant)
						state_d = ST_RF1;
					else if (cont)
						state_d = ST_T1;
					else
						state_d = ST_IDLE;
				end
			ST_RF1:
				state_d = ST_RF2;
			ST_RF2:
				state_d = resume_q ? ST_T1 : ST_IDLE;
			default:
				state_d = ST_IDLE;
		endcase
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			state_q  <= ST_IDLE;
			ch_q     <= 3'h0;
			phase_q  <= 1'b0;
			resume_q <= 1'b0;
		end
		else
		begin
			state_q <= state_d;
			ch_q    <= ch_d;
			phase_q <= phase_d;
			if (state_q == ST_HOLD)
				resume_q <= 1'b0;
			else if (pair_end)
				resume_q <= cont;
		end
	end

	// Outputs registered from next state so the cycle after grant already drives
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			bus_hold_request    <= 1'b0;
			encoded_channel_ack <= ACK_IDLE;
			dma_bus             <= '0;
		end
		else
		begin
			bus_hold_request <= (state_d != ST_IDLE);
			if ((state_d == ST_T1 || state_d == ST_T2) && is_req_d && (ch_d != ACK_NONE_CH))
				encoded_channel_ack <= ch_d;
			else
				encoded_channel_ack <= ACK_IDLE;
			dma_bus.strobe  <= (state_d == ST_T1) || (state_d == ST_RF1);
			dma_bus.t2      <= (state_d == ST_T2) || (state_d == ST_RF2);
			dma_bus.refresh <= (state_d == ST_RF1) || (state_d == ST_RF2);
			// Current registers step on this same edge, so look one step ahead
			if (pair_end && is_req_d)
				dma_bus.addr <= step_addr(cur_req_q[ch_q], cfg_q[ch_q].req_step);
			else if (pair_end)
				dma_bus.addr <= step_addr(cur_tgt_q[ch_q], cfg_q[ch_q].tgt_step);
			else
				dma_bus.addr <= is_req_d ? cur_req_q[ch_d] : cur_tgt_q[ch_d];
			// Requester is written in a read transfer, target in a write
			dma_bus.write   <= is_req_d ^ cfg_q[ch_d].dir_write;
		end
	end

	// Own drive echoes back through the sampler, so blank it for a while
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			end_of_process_line_n_out  <= 1'b1;
			end_of_process_line_n_oe_n <= 1'b1;
			eop_blank_q                <= 2'h0;
			eop_seen_q                 <= 1'b0;
		end
		else
		begin
			end_of_process_line_n_out <= 1'b0;
			end_of_process_line_n_oe_n <= !((state_d == ST_T2) && is_req_d &&
				(cur_cnt_q[ch_d] == WORD_RST));
			if (!end_of_process_line_n_oe_n)
				eop_blank_q <= EOP_BLANK_CYC;
			else if (eop_blank_q != 2'h0)
				eop_blank_q <= eop_blank_q - 2'h1;
			if ((state_q == ST_HOLD) || pair_end)
				eop_seen_q <= 1'b0;
			else if ((state_q == ST_T1 || state_q == ST_T2) && !eop_s_n &&
				end_of_process_line_n_oe_n && (eop_blank_q == 2'h0))
				eop_seen_q <= 1'b1;
		end
	end

	// AXI4-Lite write channels, taken in either order
	assign do_write = aw_hold_q && w_hold_q && !s_axi_bvalid;
	assign wch      = awaddr_q[CH_SEL_LSB +: 3];
	assign woff     = awaddr_q[4:0];
	assign wmapped  = (awaddr_q[31:WIN_MSB+1] == '0) && (woff[1:0] == 2'h0);

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			aw_hold_q     <= 1'b0;
			w_hold_q      <= 1'b0;
			s_axi_awready <= 1'b0;
			s_axi_wready  <= 1'b0;
			s_axi_bvalid  <= 1'b0;
			s_axi_bresp   <= RESP_OKAY;
			awaddr_q      <= WORD_RST;
			wdata_q       <= WORD_RST;
			wstrb_q       <= 4'h0;
		end
		else
		begin
			if (s_axi_awvalid && s_axi_awready)
			begin
				aw_hold_q     <= 1'b1;
				awaddr_q      <= s_axi_awaddr;
				s_axi_awready <= 1'b0;
			end
			else if (do_write)
			begin
				aw_hold_q     <= 1'b0;
				s_axi_awready <= 1'b1;
			end
			else
				s_axi_awready <= !aw_hold_q;
			if (s_axi_wvalid && s_axi_wready)
			begin
				w_hold_q     <= 1'b1;
				wdata_q      <= s_axi_wdata;
				wstrb_q      <= s_axi_wstrb;
				s_axi_wready <= 1'b0;
			end
			else if (do_write)
			begin
				w_hold_q     <= 1'b0;
				s_axi_wready <= 1'b1;
			end
			else
				s_axi_wready <= !w_hold_q;
			if (do_write)
			begin
				s_axi_bvalid <= 1'b1;
				s_axi_bresp  <= wmapped ? RESP_OKAY : RESP_SLVERR;
			end
			else if (s_axi_bready)
				s_axi_bvalid <= 1'b0;
		end
	end

	// Channel registers; later statements win, so software reprogramming
	// overrides a hardware update in the same cycle, except the done flag
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			armed_q <= 8'h00;
			done_q  <= 8'h00;
			for (int i = 0; i < NUM_CH; i++)
			begin
				cfg_q[i]      <= CTRL_RST;
				base_req_q[i] <= WORD_RST;
				base_tgt_q[i] <= WORD_RST;
				base_cnt_q[i] <= WORD_RST;
				cur_req_q[i]  <= WORD_RST;
				cur_tgt_q[i]  <= WORD_RST;
				cur_cnt_q[i]  <= WORD_RST;
			end
		end
		else
		begin
			if (pair_end)
			begin
				cur_req_q[ch_q] <= step_addr(cur_req_q[ch_q], cfg_q[ch_q].req_step);
				cur_tgt_q[ch_q] <= step_addr(cur_tgt_q[ch_q], cfg_q[ch_q].tgt_step);
				cur_cnt_q[ch_q] <= cur_cnt_q[ch_q] - 32'h0000_0001;
				if (term && cfg_q[ch_q].auto_init)
				begin
					cur_req_q[ch_q] <= base_req_q[ch_q];
					cur_tgt_q[ch_q] <= base_tgt_q[ch_q];
					cur_cnt_q[ch_q] <= base_cnt_q[ch_q];
				end
				else if (term)
					armed_q[ch_q] <= 1'b0;
			end
			if (do_write && wmapped)
			begin
				case (woff)
					OFF_CTRL:
					begin
						cfg_q[wch] <= dch_ctrl_t'(CTRL_W'(merge(32'(cfg_q[wch]), wdata_q,
							wstrb_q)));
						if (wstrb_q[0])
						begin
							armed_q[wch] <= wdata_q[0];
							if (wdata_q[0])
							begin
								cur_req_q[wch] <= base_req_q[wch];
								cur_tgt_q[wch] <= base_tgt_q[wch];
								cur_cnt_q[wch] <= base_cnt_q[wch];
							end
						end
					end
					OFF_BASE_REQ: base_req_q[wch] <= merge(base_req_q[wch], wdata_q, wstrb_q);
					OFF_BASE_TGT: base_tgt_q[wch] <= merge(base_tgt_q[wch], wdata_q, wstrb_q);
					OFF_BASE_CNT: base_cnt_q[wch] <= merge(base_cnt_q[wch], wdata_q, wstrb_q);
					OFF_STATUS:
						if (wstrb_q[0] && wdata_q[ST_DONE_BIT])
							done_q[wch] <= 1'b0;
					default: ;
				endcase
			end
			// Termination in the clearing cycle is kept
			if (pair_end && term)
				done_q[ch_q] <= 1'b1;
		end
	end

	// Read decode
	always_comb
	begin
		logic [2:0] rch;
		rch     = s_axi_araddr[CH_SEL_LSB +: 3];
		rd_ok   = (s_axi_araddr[31:WIN_MSB+1] == '0) && (s_axi_araddr[1:0] == 2'h0);
		rd_word = WORD_RST;
		case (s_axi_araddr[4:0])
			OFF_CTRL:     rd_word = 32'(cfg_q[rch]);
			OFF_BASE_REQ: rd_word = base_req_q[rch];
			OFF_BASE_TGT: rd_word = base_tgt_q[rch];
			OFF_BASE_CNT: rd_word = base_cnt_q[rch];
			OFF_CUR_REQ:  rd_word = cur_req_q[rch];
			OFF_CUR_TGT:  rd_word = cur_tgt_q[rch];
			OFF_CUR_CNT:  rd_word = cur_cnt_q[rch];
			OFF_STATUS:
			begin
				rd_word[ST_ARMED_BIT]  = armed_q[rch];
				rd_word[ST_DONE_BIT]   = done_q[rch];
				rd_word[ST_ACTIVE_BIT] = (ch_q == rch) &&
					(state_q == ST_T1 || state_q == ST_T2);
			end
			default: rd_word = WORD_RST;
		endcase
		if (!rd_ok)
			rd_word = WORD_RST;
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid  <= 1'b0;
			s_axi_rdata   <= WORD_RST;
			s_axi_rresp   <= RESP_OKAY;
		end
		else if (s_axi_arvalid && s_axi_arready)
		begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid  <= 1'b1;
			s_axi_rdata   <= rd_word;
			s_axi_rresp   <= rd_ok ? RESP_OKAY : RESP_SLVERR;
		end
		else if (s_axi_rvalid && s_axi_rready)
		begin
			s_axi_rvalid  <= 1'b0;
			s_axi_arready <= 1'b1;
		end
		else
			s_axi_arready <= !s_axi_rvalid;
	end

endmodule

// File: bench/dch_host_model.sv
// Host processor model: answers the hold request with a grant.
// Assumes the block's clock; the bench sets how slowly it answers.
module dch_host_model
	import dch_pkg::*;
(
	input  wire logic       aclk,
	input  wire logic       aresetn,
	input  wire logic       hold_req,
	input  wire logic [3:0] lat,
	output logic            grant
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [3:0] wait_q;

	// Grant drops with the request, so a new hold always waits again
	always_ff @(posedge aclk)
	begin
		if (!aresetn || !hold_req)
		begin
			wait_q <= 4'h0;
			grant  <= 1'h0;
		end
		else if (wait_q >= lat)
			grant <= 1'h1;
		else
			wait_q <= wait_q + 4'h1;
	end
endmodule

// File: bench/dch_dma_handshake_chk.sv
// Port-level assertions for the DMA handshake block.
// Assumes binding onto dch_dma_handshake; one clock domain.
module dch_hs_chk
	import dch_pkg::*;
(
	input wire logic        aclk,
	input wire logic        aresetn,
	input wire logic        s_axi_awready,
	input wire logic        s_axi_wready,
	input wire logic        s_axi_bvalid,
	input wire logic [31:0] s_axi_rdata,
	input wire logic        s_axi_rvalid,
	input wire logic        s_axi_rready,
	input wire logic [2:0]  encoded_channel_ack,
	input wire logic        end_of_process_line_n_out,
	input wire logic        end_of_process_line_n_oe_n,
	input wire logic        bus_hold_request,
	input wire logic        bus_hold_grant,
	input wire dch_bus_t    dma_bus
);
	timeunit 1ns;
	timeprecision 1ns;
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);

	property p_idle; !bus_hold_request |-> encoded_channel_ack == ACK_IDLE && !dma_bus.strobe;
	endproperty
	a_idle: assert property (p_idle) else $error("ack not idle");
	property p_ack_t2; dma_bus.t2 |-> $stable(encoded_channel_ack); endproperty
	a_ack_t2: assert property (p_ack_t2) else $error("ack moved in access");
	property p_start; $rose(bus_hold_grant) && bus_hold_request |=> dma_bus.strobe; endproperty
	a_start: assert property (p_start) else $error("late bus start");
	property p_hold; dma_bus.strobe |-> bus_hold_request; endproperty
	a_hold: assert property (p_hold) else $error("cycle without hold");
	property p_eop; !end_of_process_line_n_oe_n
		|-> dma_bus.t2 && !end_of_process_line_n_out ##1 end_of_process_line_n_oe_n;
	endproperty
	a_eop: assert property (p_eop) else $error("end pulse misplaced");
	property p_access; dma_bus.strobe |=> dma_bus.t2 && !dma_bus.strobe; endproperty
	a_access: assert property (p_access) else $error("access not two states");
	property p_refresh; dma_bus.refresh |-> encoded_channel_ack == ACK_IDLE; endproperty
	a_refresh: assert property (p_refresh) else $error("ack in refresh");
	property p_wbusy; $rose(s_axi_bvalid) |-> !$past(s_axi_awready) && !$past(s_axi_wready);
	endproperty
	a_wbusy: assert property (p_wbusy) else $error("write taken early");
	property p_rhold; s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
	endproperty
	a_rhold: assert property (p_rhold) else $error("read data dropped");
endmodule

bind dch_dma_handshake dch_hs_chk chk_i (.aclk, .aresetn, .s_axi_awready, .s_axi_wready,
	.s_axi_bvalid, .s_axi_rdata, .s_axi_rvalid, .s_axi_rready, .encoded_channel_ack,
	.end_of_process_line_n_out, .end_of_process_line_n_oe_n, .bus_hold_request,
	.bus_hold_grant, .dma_bus);

// File: bench/dch_dma_handshake_bench.sv
// Self-checking bench for the DMA handshake block over AXI4-Lite.
// Assumes the host model and checker are compiled ahead of it.
module dch_dma_handshake_bench
	import dch_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ns;
	logic        aclk = 1'h0, aresetn = 1'h0, refresh_request = 1'h0, periph_eop_n = 1'h1;
	logic [31:0] s_axi_awaddr = '0, s_axi_wdata = '0, s_axi_araddr = '0, s_axi_rdata;
	logic [3:0]  s_axi_wstrb = 4'hF, lat = 4'h0;
	logic        s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
	logic        s_axi_arvalid = 1'h0, s_axi_rready = 1'h0, s_axi_awready, s_axi_wready;
	logic        s_axi_bvalid, s_axi_arready, s_axi_rvalid, bus_hold_request, bus_hold_grant;
	logic [1:0]  s_axi_bresp, s_axi_rresp;
	logic [7:0]  channel_request = 8'h00;
	logic [2:0]  encoded_channel_ack;
	logic        end_of_process_line_n_out, end_of_process_line_n_oe_n;
	wire         end_of_process_line_n_in;
	dch_bus_t    dma_bus;
	int          bad_count = 0, n_tests = 0, cyc = 0, n_eop = 0, n_ref = 0;
	logic [35:0] acc[$];

	// Pulled-up shared line: either party pulls it low
	assign end_of_process_line_n_in =
		(!end_of_process_line_n_oe_n && !end_of_process_line_n_out) ? 1'h0 : periph_eop_n;

	always #20 aclk = ~aclk;

	dch_dma_handshake uut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
		.s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
		.s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
		.s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .channel_request, .encoded_channel_ack,
		.end_of_process_line_n_in, .end_of_process_line_n_out, .end_of_process_line_n_oe_n,
		.bus_hold_request, .bus_hold_grant, .refresh_request, .dma_bus);
	dch_host_model host (.aclk, .aresetn, .hold_req(bus_hold_request), .lat,
		.grant(bus_hold_grant));

	task automatic end_of_test();
		$display("comparisons %0d mismatches %0d", n_tests, bad_count);
		if (bad_count == 0 && n_tests > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask

	// Every non-refresh access of a held bus is logged as ack, write, address
	always @(posedge aclk)
	begin
		cyc++;
		if (dma_bus.strobe && !dma_bus.refresh)
			acc.push_back({encoded_channel_ack, dma_bus.write, dma_bus.addr});
		if (!end_of_process_line_n_oe_n)
			n_eop++;
		if (dma_bus.refresh && dma_bus.t2)
			n_ref++;
		if (cyc == 20000)
		begin
			bad_count++;
			$display("unexpected at %0t: run hung", $time);
			end_of_test();
		end
	end

	task automatic chk(input logic [63:0] got, input logic [63:0] exp);
		n_tests++;
		if (got !== exp)
		begin
			bad_count++;
			$display("unexpected at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic wr(input logic [31:0] a, input logic [31:0] d, output logic [1:0] r);
		@(posedge aclk);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'h1;
		s_axi_wvalid <= 1'h1;
		s_axi_bready <= 1'h1;
		fork
			begin do @(posedge aclk); while (!s_axi_awready); s_axi_awvalid <= 1'h0; end
			begin do @(posedge aclk); while (!s_axi_wready); s_axi_wvalid <= 1'h0; end
		join
		do @(posedge aclk); while (!s_axi_bvalid);
		r = s_axi_bresp;
		s_axi_bready <= 1'h0;
	endtask

	// Read ready is raised late on purpose so the slave must hold its answer
	task automatic rd(input logic [31:0] a, output logic [31:0] d, output logic [1:0] r);
		@(posedge aclk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'h1;
		do @(posedge aclk); while (!s_axi_arready);
		s_axi_arvalid <= 1'h0;
		do @(posedge aclk); while (!s_axi_rvalid);
		s_axi_rready <= 1'h1;
		@(posedge aclk);
		d = s_axi_rdata;
		r = s_axi_rresp;
		s_axi_rready <= 1'h0;
	endtask

	function automatic logic [31:0] ra(input logic [2:0] ch, input logic [4:0] off);
		return {24'h0, ch, off};
	endfunction

	function automatic logic [31:0] stp(input logic [31:0] a, input dch_step_t m);
		return (m == STEP_INC) ? a + 32'h1 : (m == STEP_DEC) ? a - 32'h1 : a;
	endfunction

	task automatic arm(input logic [2:0] ch, input dch_ctrl_t c, input logic [31:0] cnt);
		logic [1:0] s;
		wr(ra(ch, OFF_BASE_REQ), {20'h1, ch, 9'h0}, s);
		wr(ra(ch, OFF_BASE_TGT), {20'h8, ch, 9'h0}, s);
		wr(ra(ch, OFF_BASE_CNT), cnt, s);
		wr(ra(ch, OFF_CTRL), {23'h0, c}, s);
		acc.delete();
		n_eop = 0;
	endtask

	task automatic t_reset();
		logic [31:0] d;
		logic [1:0]  s;
		chk({encoded_channel_ack, bus_hold_request, end_of_process_line_n_oe_n}, 5'h11);
		rd(32'h0000_0100, d, s);
		chk({s, d}, {RESP_SLVERR, 32'h0});
		wr(32'h0000_0006, 32'h1, s);
		chk(s, RESP_SLVERR);
		rd(ra(3'h3, OFF_CTRL), d, s);
		chk({s, d}, {RESP_OKAY, WORD_RST});
		$display("test reset done");
	endtask

	task automatic xfer(input logic [2:0] ch, input dch_ctrl_t c, input logic [31:0] cnt,
		input int np, input logic [3:0] l);
		logic [31:0] r, t, d;
		logic [1:0]  s;
		lat <= l;
		arm(ch, c, cnt);
		channel_request[ch] <= 1'h1;
		while (acc.size() < 2 * np) @(posedge aclk);
		channel_request[ch] <= 1'h0;
		do @(posedge aclk); while (bus_hold_request);
		for (int i = 0; i < np; i++)
		begin
			if (i % (int'(cnt) + 1) == 0)
			begin
				r = {20'h1, ch, 9'h0};
				t = {20'h8, ch, 9'h0};
			end
			chk(acc[2 * i], c.dir_write ? {ch, 1'h0, r} : {ACK_IDLE, 1'h0, t});
			chk(acc[2 * i + 1], c.dir_write ? {ACK_IDLE, 1'h1, t} : {ch, 1'h1, r});
			r = stp(r, c.req_step);
			t = stp(t, c.tgt_step);
		end
		rd(ra(ch, OFF_BASE_CNT), d, s);
		chk(d, cnt);
		rd(ra(ch, OFF_STATUS), d, s);
		if (c.auto_init)
			chk(d[ST_ARMED_BIT], 1'h1);
		else
		begin
			chk(d, 32'h2);
			chk(n_eop, 1);
			rd(ra(ch, OFF_CUR_REQ), d, s);
			chk(d, r);
			rd(ra(ch, OFF_CUR_CNT), d, s);
			chk(d, 32'hFFFF_FFFF);
		end
		wr(ra(ch, OFF_CTRL), 32'h0, s);
		wr(ra(ch, OFF_STATUS), 32'h2, s);
		$display("test transfer on channel %0d done", ch);
	endtask

	task automatic t_eop();
		logic [31:0] d;
		logic [1:0]  s;
		arm(3'h5, '{1'h1, 1'h1, STEP_INC, STEP_INC, 1'h1, 1'h0, 1'h1}, 32'h20);
		channel_request[5] <= 1'h1;
		while (acc.size() < 2) @(posedge aclk);
		periph_eop_n <= 1'h0;
		do @(posedge aclk); while (bus_hold_request);
		periph_eop_n <= 1'h1;
		channel_request[5] <= 1'h0;
		chk(acc.size() < 20, 1'h1);
		rd(ra(3'h5, OFF_STATUS), d, s);
		chk(d, 32'h2);
		$display("test peripheral end done");
	endtask

	task automatic t_prio();
		arm(3'h6, '{1'h0, 1'h1, STEP_INC, STEP_INC, 1'h1, 1'h0, 1'h1}, 32'h1);
		arm(3'h1, '{1'h0, 1'h1, STEP_INC, STEP_INC, 1'h1, 1'h0, 1'h1}, 32'h1);
		channel_request <= 8'h42;
		while (acc.size() < 1) @(posedge aclk);
		refresh_request <= 1'h1;
		while (n_ref == 0) @(posedge aclk);
		refresh_request <= 1'h0;
		while (acc.size() < 8) @(posedge aclk);
		channel_request <= 8'h00;
		chk(acc[0][35:33], 3'h1);
		chk(acc[4][35:33], 3'h6);
		chk(n_ref, 1);
		$display("test priority and refresh done");
	endtask

	initial
	begin
		repeat (20) @(posedge aclk);
		aresetn <= 1'h1;
		@(posedge aclk);
		t_reset();
		xfer(3'h2, '{1'h0, 1'h1, STEP_DEC, STEP_INC, 1'h1, 1'h0, 1'h1}, 32'h2, 3, 4'h0);
		xfer(3'h4, '{1'h0, 1'h0, STEP_HOLD, STEP_DEC, 1'h0, 1'h1, 1'h1}, 32'h1, 4, 4'h5);
		xfer(3'h7, '{1'h0, 1'h1, STEP_INC, STEP_HOLD, 1'h0, 1'h0, 1'h1}, 32'h0, 1, 4'h2);
		t_eop();
		t_prio();
		end_of_test();
	end
endmodule
